// ==== rtl/rcp_pins.sv ====
// Our own choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module rcp_pins
  import rcp_pkg::*;
#(
  parameter int unsigned P_CLK_PER_MS = rcp_pkg::CLK_PER_MS,
  parameter int unsigned P_BAUD_DIV = rcp_pkg::BAUD_DIV
) (
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output logic o_irq,
  input wire logic [7:0] i_remote_status_lines,
  output logic [7:0] o_remote_status_lines,
  output logic [7:0] o_remote_status_lines_oe,
  input wire logic i_dir_sel_low_group,
  input wire logic i_dir_sel_high_group,
  input wire logic i_toggle_output_select,
  input wire logic i_sleep_request_n,
  input wire logic i_reply_permit,
  input wire logic i_pair_button,
  input wire logic i_cfg_serial_rx,
  output logic o_cfg_serial_tx,
  output logic o_rx_amp_enable,
  output logic o_tx_amp_enable,
  output logic o_activity_indicator,
  output logic o_reply_seen
);
  import rcp_pkg::*;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [14:0] pin_meta_r;
  logic [14:0] pin_sync_r;
  logic [7:0] in_s;
  logic dirl_s, dirh_s, tog_s, sleep_n_s, permit_s, pb_s, urx_s;

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pin_meta_r <= 15'h4000;
      pin_sync_r <= 15'h4000;
    end else begin
      pin_meta_r <= {i_cfg_serial_rx, i_sleep_request_n, i_reply_permit, i_pair_button,
                     i_toggle_output_select, i_dir_sel_high_group, i_dir_sel_low_group,
                     i_remote_status_lines};
      pin_sync_r <= pin_meta_r;
    end
  end

  assign in_s = pin_sync_r[7:0];
  assign dirl_s = pin_sync_r[8];
  assign dirh_s = pin_sync_r[9];
  assign tog_s = pin_sync_r[10];
  assign pb_s = pin_sync_r[11];
  assign permit_s = pin_sync_r[12];
  assign sleep_n_s = pin_sync_r[13];
  assign urx_s = pin_sync_r[14];

  // ****************************************
  // Millisecond enable
  // ****************************************
  logic [15:0] div_r, div_nxt;
  logic ms_tick;

  assign ms_tick = (div_r == 16'(P_CLK_PER_MS - 1));

  always_comb begin
    div_nxt = ms_tick ? 16'h0000 : div_r + 16'h0001;
  end

  // ****************************************
  // Register bus, one wait state
  // ****************************************
  logic ack_r, ack_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic wr_en;
  logic [1:0] ctrl_r, ctrl_nxt;
  logic [IRQ_W-1:0] stat_r, stat_nxt, mask_r, mask_nxt;
  logic irq_r, irq_nxt;
  logic [IRQ_W-1:0] ev;
  logic [7:0] dir_r;
  logic tog_r;
  logic sleep;
  logic [4:0] reply_ms_r;
  logic utx_ready;
  logic [7:0] urx_data;
  logic urx_valid;
  logic utx_valid;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] base);
    return a == base;
  endfunction

  assign sleep = !sleep_n_s;
  assign wr_en = i_avs_write && ack_r;
  assign utx_valid = wr_en && hit(i_avs_address, A_UART_TX);
  assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !ack_r;

  always_comb begin
    ack_nxt = (i_avs_read || i_avs_write) && !ack_r;
    rdata_nxt = rdata_r;
    if (i_avs_read && !ack_r) begin
      case (i_avs_address)
        A_CTRL: rdata_nxt = {30'h0, ctrl_r};
        A_PINS: rdata_nxt = {13'h0, sleep, permit_s, tog_r, dir_r, in_s};
        A_ACK: rdata_nxt = {31'h0, reply_ms_r != 5'h00};
        A_IRQ_STAT: rdata_nxt = {27'h0, stat_r};
        A_IRQ_MASK: rdata_nxt = {27'h0, mask_r};
        A_UART_TX: rdata_nxt = {31'h0, utx_ready};
        A_UART_RX: rdata_nxt = {24'h0, urx_data};
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
    ctrl_nxt = ctrl_r;
    mask_nxt = mask_r;
    stat_nxt = stat_r;
    if (wr_en && hit(i_avs_address, A_CTRL)) begin
      ctrl_nxt = i_avs_writedata[1:0];
    end
    if (wr_en && hit(i_avs_address, A_IRQ_MASK)) begin
      mask_nxt = i_avs_writedata[IRQ_W-1:0];
    end
    if (wr_en && hit(i_avs_address, A_IRQ_STAT)) begin
      stat_nxt = stat_r & ~i_avs_writedata[IRQ_W-1:0];
    end
    stat_nxt = stat_nxt | ev;
    irq_nxt = |(stat_nxt & mask_nxt);
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      div_r <= 16'h0000;
      ack_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      ctrl_r <= CTRL_RST;
      stat_r <= IRQ_RST;
      mask_r <= IRQ_RST;
      irq_r <= 1'b0;
    end else begin
      div_r <= div_nxt;
      ack_r <= ack_nxt;
      rdata_r <= rdata_nxt;
      ctrl_r <= ctrl_nxt;
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign o_avs_readdata = rdata_r;
  assign o_irq = irq_r;

  // ****************************************
  // Status lines and straps
  // ****************************************
  logic [1:0] strap_cnt_r, strap_cnt_nxt;
  logic [7:0] dir_nxt;
  logic tog_nxt;
  logic [7:0] out_r, out_nxt, old_r, old_nxt, prev_in_r, prev_in_nxt, oe_r, oe_nxt;
  logic [9:0] hold_r, hold_nxt;
  logic [7:0] pkt;
  logic pkt_wr;

  assign pkt = i_avs_writedata[7:0];
  assign pkt_wr = wr_en && hit(i_avs_address, A_RX_PKT) && !sleep;

  always_comb begin
    strap_cnt_nxt = strap_cnt_r;
    dir_nxt = dir_r;
    tog_nxt = tog_r;
    // Straps pass the synchroniser first, so capture runs until its third edge
    if (strap_cnt_r != 2'h3) begin
      strap_cnt_nxt = strap_cnt_r + 2'h1;
      dir_nxt = {{4{dirh_s}}, {4{dirl_s}}};
      tog_nxt = tog_s;
    end
    out_nxt = out_r;
    old_nxt = old_r;
    hold_nxt = hold_r;
    if (pkt_wr) begin
      old_nxt = pkt;
      hold_nxt = 10'(HOLD_MS);
      if (tog_r) begin
        out_nxt = out_r ^ (pkt & ~old_r);
      end else begin
        out_nxt = pkt;
      end
    end else if (!tog_r && ms_tick && hold_r != 10'h000) begin
      hold_nxt = hold_r - 10'h001;
      if (hold_r == 10'h001) begin
        out_nxt = 8'h00;
      end
    end
    prev_in_nxt = in_s;
    oe_nxt = sleep ? 8'h00 : ~dir_nxt;
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      strap_cnt_r <= 2'h0;
      dir_r <= 8'hFF;
      tog_r <= 1'b0;
      out_r <= 8'h00;
      old_r <= 8'h00;
      hold_r <= 10'h000;
      prev_in_r <= 8'h00;
      oe_r <= 8'h00;
    end else begin
      strap_cnt_r <= strap_cnt_nxt;
      dir_r <= dir_nxt;
      tog_r <= tog_nxt;
      out_r <= out_nxt;
      old_r <= old_nxt;
      hold_r <= hold_nxt;
      prev_in_r <= prev_in_nxt;
      oe_r <= oe_nxt;
    end
  end

  assign o_remote_status_lines = out_r;
  assign o_remote_status_lines_oe = oe_r;

  // ****************************************
  // Pair button, reply and amplifiers
  // ****************************************
  logic pb_db_r, pb_db_nxt;
  logic [2:0] press_r, press_nxt;
  logic [10:0] win_r, win_nxt;
  logic [4:0] reply_ms_nxt;
  logic amp_rx_r, amp_rx_nxt, amp_tx_r, amp_tx_nxt;
  logic pb_rise, fr_hit;

  assign pb_rise = ms_tick && pb_s && !pb_db_r && !sleep;
  assign fr_hit = pb_rise && (press_r == 3'(FR_PRESSES - 1));

  always_comb begin
    pb_db_nxt = ms_tick ? pb_s : pb_db_r;
    press_nxt = press_r;
    win_nxt = win_r;
    if (pb_rise) begin
      win_nxt = 11'(FR_WIN_MS);
      press_nxt = fr_hit ? 3'h0 : press_r + 3'h1;
    end else if (ms_tick && win_r != 11'h000) begin
      win_nxt = win_r - 11'h001;
      if (win_r == 11'h001) begin
        press_nxt = 3'h0;
      end
    end
    reply_ms_nxt = reply_ms_r;
    if (wr_en && hit(i_avs_address, A_ACK) && i_avs_writedata[0] && !sleep) begin
      reply_ms_nxt = 5'(REPLY_MS);
    end else if (ms_tick && reply_ms_r != 5'h00) begin
      reply_ms_nxt = reply_ms_r - 5'h01;
    end
    amp_rx_nxt = ctrl_nxt[CTRL_RX_ON] && !sleep;
    amp_tx_nxt = ctrl_nxt[CTRL_TX_ON] && !sleep;
    ev = '0;
    ev[EV_IN_RISE] = |(in_s & ~prev_in_r & dir_r) && !sleep;
    ev[EV_ACK_DUE] = pkt_wr && permit_s;
    ev[EV_PAIR] = pb_rise;
    ev[EV_FACTORY] = fr_hit;
    ev[EV_UART_RX] = urx_valid && !sleep;
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pb_db_r <= 1'b0;
      press_r <= 3'h0;
      win_r <= 11'h000;
      reply_ms_r <= 5'h00;
      amp_rx_r <= 1'b0;
      amp_tx_r <= 1'b0;
    end else begin
      pb_db_r <= pb_db_nxt;
      press_r <= press_nxt;
      win_r <= win_nxt;
      reply_ms_r <= reply_ms_nxt;
      amp_rx_r <= amp_rx_nxt;
      amp_tx_r <= amp_tx_nxt;
    end
  end

  assign o_rx_amp_enable = amp_rx_r;
  assign o_tx_amp_enable = amp_tx_r;
  assign o_reply_seen = reply_ms_r != 5'h00;

  // ****************************************
  // Activity indicator
  // ****************************************
  rcp_ind_t ind;
  logic [10:0] ind_on, ind_per;

  always_comb begin
    if (sleep) begin
      ind = IND_OFF;
    end else if (amp_tx_r) begin
      ind = IND_TX;
    end else if (stat_r[EV_PAIR]) begin
      ind = IND_PAIR;
    end else if (amp_rx_r) begin
      ind = IND_RX;
    end else begin
      ind = IND_IDLE;
    end
    case (ind)
      IND_TX: begin
        ind_on = IND_TX_ON;
        ind_per = IND_TX_PER;
      end
      IND_PAIR: begin
        ind_on = IND_PAIR_ON;
        ind_per = IND_PAIR_PER;
      end
      IND_RX: begin
        ind_on = IND_RX_ON;
        ind_per = IND_RX_PER;
      end
      default: begin
        ind_on = 11'h000;
        ind_per = 11'h000;
      end
    endcase
  end

  rcp_flash u_flash (
    .i_core_clk(i_core_clk),
    .i_arst_n(i_arst_n),
    .i_ms_tick(ms_tick),
    .i_on_ms(ind_on),
    .i_per_ms(ind_per),
    .o_led(o_activity_indicator)
  );

  // ****************************************
  // Serial configuration port
  // ****************************************
  rcp_uart #(
    .P_DIV(P_BAUD_DIV)
  ) u_uart (
    .i_core_clk(i_core_clk),
    .i_arst_n(i_arst_n),
    .i_tx_valid(utx_valid),
    .i_tx_data(i_avs_writedata[7:0]),
    .o_tx_ready(utx_ready),
    .o_tx(o_cfg_serial_tx),
    .i_rx(urx_s),
    .o_rx_valid(urx_valid),
    .o_rx_data(urx_data)
  );
endmodule
`default_nettype wire

// ==== rtl/rcp_pkg.sv ====
package rcp_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned CLK_PER_MS = CLK_HZ / 1000;
  localparam int unsigned BAUD = 115_200;
  localparam int unsigned BAUD_DIV = CLK_HZ / BAUD;
  localparam int unsigned REPLY_MS = 20;
  localparam int unsigned HOLD_MS = 760;
  localparam int unsigned FR_WIN_MS = 2000;
  localparam int unsigned FR_PRESSES = 5;

  // ****************************************
  // Register map (byte offsets)
  // ****************************************
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_RX_PKT = 8'h04;
  localparam logic [7:0] A_PINS = 8'h08;
  localparam logic [7:0] A_ACK = 8'h0C;
  localparam logic [7:0] A_IRQ_STAT = 8'h10;
  localparam logic [7:0] A_IRQ_MASK = 8'h14;
  localparam logic [7:0] A_UART_TX = 8'h18;
  localparam logic [7:0] A_UART_RX = 8'h1C;

  // ****************************************
  // Fields and reset values
  // ****************************************
  localparam int unsigned CTRL_RX_ON = 0;
  localparam int unsigned CTRL_TX_ON = 1;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam int unsigned PINS_DIR = 8;
  localparam int unsigned PINS_TOG = 16;
  localparam int unsigned PINS_PERMIT = 17;
  localparam int unsigned PINS_SLEEP = 18;
  localparam int unsigned IRQ_W = 5;
  localparam int unsigned EV_IN_RISE = 0;
  localparam int unsigned EV_ACK_DUE = 1;
  localparam int unsigned EV_PAIR = 2;
  localparam int unsigned EV_FACTORY = 3;
  localparam int unsigned EV_UART_RX = 4;
  localparam logic [IRQ_W-1:0] IRQ_RST = 5'h00;

  // ****************************************
  // Indicator flash timing (ms)
  // ****************************************
  localparam logic [10:0] IND_RX_ON = 11'h014;
  localparam logic [10:0] IND_RX_PER = 11'h3E8;
  localparam logic [10:0] IND_TX_ON = 11'h032;
  localparam logic [10:0] IND_TX_PER = 11'h064;
  localparam logic [10:0] IND_PAIR_ON = 11'h1F4;
  localparam logic [10:0] IND_PAIR_PER = 11'h3E8;

  typedef enum logic [2:0] {IND_OFF, IND_IDLE, IND_RX, IND_TX, IND_PAIR} rcp_ind_t;

endpackage

// ==== rtl/rcp_flash.sv ====
`timescale 1ns/1ps
`default_nettype none
module rcp_flash (
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  input wire logic i_ms_tick,
  input wire logic [10:0] i_on_ms,
  input wire logic [10:0] i_per_ms,
  output logic o_led
);
  logic [10:0] cnt_r;
  logic [10:0] cnt_nxt;
  logic led_r;
  logic led_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    if (i_ms_tick) begin
      cnt_nxt = (cnt_r + 11'h001 >= i_per_ms) ? 11'h000 : cnt_r + 11'h001;
    end
    led_nxt = (i_per_ms != 11'h000) && (cnt_nxt < i_on_ms);
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt_r <= 11'h000;
      led_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      led_r <= led_nxt;
    end
  end

  assign o_led = led_r;
endmodule
`default_nettype wire

// ==== rtl/rcp_uart.sv ====
`timescale 1ns/1ps
`default_nettype none
module rcp_uart #(
  parameter int unsigned P_DIV = 347
) (
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  input wire logic i_tx_valid,
  input wire logic [7:0] i_tx_data,
  output logic o_tx_ready,
  output logic o_tx,
  input wire logic i_rx,
  output logic o_rx_valid,
  output logic [7:0] o_rx_data
);
  logic [9:0] tsh_r, tsh_nxt, rsh_r, rsh_nxt;
  logic [3:0] tcnt_r, tcnt_nxt, rcnt_r, rcnt_nxt;
  logic [15:0] tdiv_r, tdiv_nxt, rdiv_r, rdiv_nxt;
  logic rval_r, rval_nxt;
  logic [7:0] rdat_r, rdat_nxt;

  // ****************************************
  // Transmitter, 8N1, idle high
  // ****************************************
  always_comb begin
    tsh_nxt = tsh_r;
    tcnt_nxt = tcnt_r;
    tdiv_nxt = tdiv_r;
    if (tcnt_r == 4'h0) begin
      if (i_tx_valid) begin
        tsh_nxt = {1'b1, i_tx_data, 1'b0};
        tcnt_nxt = 4'hA;
        tdiv_nxt = 16'h0000;
      end
    end else if (tdiv_r == 16'(P_DIV - 1)) begin
      tdiv_nxt = 16'h0000;
      tsh_nxt = {1'b1, tsh_r[9:1]};
      tcnt_nxt = tcnt_r - 4'h1;
    end else begin
      tdiv_nxt = tdiv_r + 16'h0001;
    end
  end

  // ****************************************
  // Receiver, samples mid-bit
  // ****************************************
  always_comb begin
    rsh_nxt = rsh_r;
    rcnt_nxt = rcnt_r;
    rdiv_nxt = rdiv_r;
    rval_nxt = 1'b0;
    rdat_nxt = rdat_r;
    if (rcnt_r == 4'h0) begin
      if (!i_rx) begin
        rcnt_nxt = 4'hA;
        rdiv_nxt = 16'(P_DIV / 2);
      end
    end else if (rdiv_r == 16'h0000) begin
      rdiv_nxt = 16'(P_DIV - 1);
      rsh_nxt = {i_rx, rsh_r[9:1]};
      rcnt_nxt = rcnt_r - 4'h1;
      if (rcnt_r == 4'h1 && !rsh_nxt[0] && i_rx) begin
        rval_nxt = 1'b1;
        rdat_nxt = rsh_nxt[8:1];
      end
    end else begin
      rdiv_nxt = rdiv_r - 16'h0001;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tsh_r <= 10'h3FF;
      tcnt_r <= 4'h0;
      tdiv_r <= 16'h0000;
      rsh_r <= 10'h3FF;
      rcnt_r <= 4'h0;
      rdiv_r <= 16'h0000;
      rval_r <= 1'b0;
      rdat_r <= 8'h00;
    end else begin
      tsh_r <= tsh_nxt;
      tcnt_r <= tcnt_nxt;
      tdiv_r <= tdiv_nxt;
      rsh_r <= rsh_nxt;
      rcnt_r <= rcnt_nxt;
      rdiv_r <= rdiv_nxt;
      rval_r <= rval_nxt;
      rdat_r <= rdat_nxt;
    end
  end

  assign o_tx_ready = (tcnt_r == 4'h0);
  assign o_tx = tsh_r[0];
  assign o_rx_valid = rval_r;
  assign o_rx_data = rdat_r;
endmodule
`default_nettype wire

// ==== tb/rcp_pins_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module rcp_pins_chk
  import rcp_pkg::*;
#(
  parameter int unsigned P_CLK_PER_MS = 10
) (
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic o_avs_waitrequest,
  input wire logic [7:0] o_remote_status_lines,
  input wire logic [7:0] o_remote_status_lines_oe,
  input wire logic i_dir_sel_low_group,
  input wire logic i_dir_sel_high_group,
  input wire logic i_toggle_output_select,
  input wire logic i_sleep_request_n,
  input wire logic o_rx_amp_enable,
  input wire logic o_tx_amp_enable,
  input wire logic o_activity_indicator,
  input wire logic o_reply_seen
);
  // ****************************************
  // Helper state
  // ****************************************
  localparam int HOLD_LIM = (HOLD_MS + 2) * P_CLK_PER_MS;
  logic take, ack_take, d1_r, d2_r;
  logic [7:0] last_r, prev_r;
  logic [3:0] awake_r;
  int since_r, run_r;
  assign take = i_avs_write && !o_avs_waitrequest && i_avs_address == A_RX_PKT;
  assign ack_take = i_avs_write && !o_avs_waitrequest && i_avs_address == A_ACK
    && i_avs_writedata[0];
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      d1_r <= 1'b0;
      d2_r <= 1'b0;
      last_r <= 8'h00;
      prev_r <= 8'h00;
      awake_r <= 4'h0;
      since_r <= 0;
      run_r <= 0;
    end else begin
      d1_r <= take;
      d2_r <= d1_r;
      if (take) begin
        prev_r <= last_r;
        last_r <= i_avs_writedata[7:0];
      end
      awake_r <= !i_sleep_request_n ? 4'h0 : (awake_r == 4'h8 ? awake_r : awake_r + 4'h1);
      since_r <= take ? 0 : (since_r == HOLD_LIM ? since_r : since_r + 1);
      run_r <= o_reply_seen ? run_r + 1 : 0;
    end
  end
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_arst_n);
  sequence s_asleep;
    !i_sleep_request_n [*4];
  endsequence
  sequence s_pkt_in;
    take && awake_r == 4'h8;
  endsequence
  rx_amp_sleep_a: assert property (s_asleep |-> !o_rx_amp_enable)
    else $error("rx amp on while asleep");
  tx_amp_sleep_a: assert property (s_asleep |-> !o_tx_amp_enable)
    else $error("tx amp on while asleep");
  oe_sleep_a: assert property (s_asleep |-> o_remote_status_lines_oe == 8'h00)
    else $error("lines driven while asleep");
  ind_sleep_a: assert property (s_asleep ##1 !i_sleep_request_n [*2] |-> !o_activity_indicator)
    else $error("indicator lit while asleep");
  dir_oe_a: assert property (awake_r == 4'h8 |-> o_remote_status_lines_oe ==
    {{4{!i_dir_sel_high_group}}, {4{!i_dir_sel_low_group}}}) else $error("line direction wrong");
  pkt_toggle_a: assert property ((s_pkt_in and i_toggle_output_select) |-> ##2
    o_remote_status_lines == ($past(o_remote_status_lines, 2) ^ (last_r & ~prev_r)))
    else $error("toggle result wrong");
  tog_hold_a: assert property (i_toggle_output_select && !d1_r && !d2_r
    |-> $stable(o_remote_status_lines)) else $error("output changed without packet");
  pkt_copy_a: assert property ((s_pkt_in and !i_toggle_output_select)
    |-> ##2 o_remote_status_lines == last_r) else $error("momentary output wrong");
  mom_expire_a: assert property (!i_toggle_output_select && since_r == HOLD_LIM
    |-> o_remote_status_lines == 8'h00) else $error("momentary output not cleared");
  reply_rise_a: assert property (ack_take |-> ##2 o_reply_seen)
    else $error("reply seen not raised");
  reply_len_a: assert property ($fell(o_reply_seen) |->
    run_r >= (REPLY_MS - 1) * P_CLK_PER_MS - 1 && run_r <= REPLY_MS * P_CLK_PER_MS + 1)
    else $error("reply seen length wrong");
endmodule
bind rcp_pins rcp_pins_chk #(.P_CLK_PER_MS(P_CLK_PER_MS)) u_chk (
  .i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_avs_address(i_avs_address),
  .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
  .o_avs_waitrequest(o_avs_waitrequest), .o_remote_status_lines(o_remote_status_lines),
  .o_remote_status_lines_oe(o_remote_status_lines_oe),
  .i_dir_sel_low_group(i_dir_sel_low_group), .i_dir_sel_high_group(i_dir_sel_high_group),
  .i_toggle_output_select(i_toggle_output_select), .i_sleep_request_n(i_sleep_request_n),
  .o_rx_amp_enable(o_rx_amp_enable), .o_tx_amp_enable(o_tx_amp_enable),
  .o_activity_indicator(o_activity_indicator), .o_reply_seen(o_reply_seen));
`default_nettype wire

// ==== tb/rcp_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module rcp_host (
  input wire logic [7:0] i_line_out,
  input wire logic [7:0] i_line_oe,
  input wire logic [7:0] i_host_drive,
  input wire logic i_serial_tx,
  output logic [7:0] o_line,
  output logic o_serial_rx
);
  // ****************************************
  // Pin side
  // ****************************************
  // Where the device does not drive a line, the host's contact sets it
  assign o_line = (i_line_oe & i_line_out) | (~i_line_oe & i_host_drive);
  // Far end echoes every byte; the line idles high with the device output
  assign o_serial_rx = i_serial_tx;
endmodule
`default_nettype wire

// ==== tb/remote_control_pin_logic_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin num_errors++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, got, exp); end end
module remote_control_pin_logic_tb;
  import rcp_pkg::*;
  localparam int MS = 10;
  logic clk = 0, rst_n = 0, rd = 0, wr = 0, wreq, irq, stx, srx, rxa, txa, ind, rseen;
  logic dlo = 0, dhi = 1, tog = 1, sleep_n = 1, permit = 0, btn = 0;
  logic [7:0] addr = 0, line, lout, loe, drive = 0, exp_out, last_pkt, b;
  logic [31:0] wdata = 0, rdata, r;
  int num_errors = 0, tests_run = 0, hi, n;
  rcp_pins #(.P_CLK_PER_MS(MS), .P_BAUD_DIV(8)) DUT (
    .i_core_clk(clk), .i_arst_n(rst_n), .i_avs_address(addr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wdata), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wreq), .o_irq(irq), .i_remote_status_lines(line),
    .o_remote_status_lines(lout), .o_remote_status_lines_oe(loe),
    .i_dir_sel_low_group(dlo), .i_dir_sel_high_group(dhi), .i_toggle_output_select(tog),
    .i_sleep_request_n(sleep_n), .i_reply_permit(permit), .i_pair_button(btn),
    .i_cfg_serial_rx(srx), .o_cfg_serial_tx(stx), .o_rx_amp_enable(rxa),
    .o_tx_amp_enable(txa), .o_activity_indicator(ind), .o_reply_seen(rseen));
  rcp_host u_host (.i_line_out(lout), .i_line_oe(loe), .i_host_drive(drive),
    .i_serial_tx(stx), .o_line(line), .o_serial_rx(srx));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic wrap_up();
    $display("Checks: %0d, errors: %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    do begin
      @(posedge clk);
    end while (wreq !== 1'b0);
    r = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic do_reset(input logic t);
    @(posedge clk);
    rst_n <= 1'b0;
    tog <= t;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (10) @(posedge clk);
    exp_out = 8'h00;
    last_pkt = 8'h00;
  endtask
  // Reference model of the output lines for both modes
  task automatic pkt(input logic [7:0] p);
    bus(1'b1, A_RX_PKT, {24'h0, p});
    exp_out = tog ? exp_out ^ (p & ~last_pkt) : p;
    last_pkt = p;
    repeat (3) @(posedge clk);
    `CHK(lout, exp_out)
    `CHK(line[3:0], exp_out[3:0])
  endtask
  task automatic press();
    btn <= 1'b1;
    repeat (3 * MS) @(posedge clk);
    btn <= 1'b0;
    repeat (3 * MS) @(posedge clk);
  endtask
  initial begin
    forever #12.5 clk = ~clk;
  end
  initial begin
    // Whole sequence needs about 18k cycles
    #2_000_000;
    num_errors++;
    wrap_up();
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    void'($urandom(32'h05CB));
    do_reset(1'b1);
    drive <= 8'($urandom) & 8'hC0;
    repeat (4) @(posedge clk);
    bus(1'b0, A_PINS, 0);
    `CHK(r[18:0], {3'b001, 8'hF0, drive[7:4], 4'h0})
    foreach (b[i]) begin
      pkt(8'($urandom));
    end
    pkt(8'hFF);
    pkt(8'hFF);
    pkt(8'h00);
    pkt(8'h01);
    for (int i = 0; i < 3; i++) begin
      bus(1'b0, i == 0 ? A_CTRL : (i == 1 ? A_IRQ_MASK : 8'h20), 0);
      `CHK(r, 32'h0)
    end
    bus(1'b0, A_IRQ_STAT, 0);
    `CHK(r[4:0], {4'h0, |drive[7:4]})
    permit <= 1'b1;
    pkt(8'($urandom));
    bus(1'b1, A_IRQ_MASK, 32'h1F);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b1)
    bus(1'b1, A_IRQ_STAT, 32'h03);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b0)
    drive[4] <= 1'b1;
    repeat (6) @(posedge clk);
    bus(1'b0, A_IRQ_STAT, 0);
    `CHK({irq, r[4:0]}, 6'h21)
    bus(1'b1, A_IRQ_MASK, 32'h1E);
    bus(1'b1, A_IRQ_STAT, 32'h01);
    drive[5] <= 1'b1;
    repeat (6) @(posedge clk);
    bus(1'b0, A_IRQ_STAT, 0);
    `CHK({irq, r[4:0]}, 6'h01)
    bus(1'b1, A_IRQ_STAT, 32'h1F);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, A_CTRL, 32'(i));
      repeat (3) @(posedge clk);
      `CHK({txa, rxa}, 2'(i))
    end
    hi = 0;
    repeat (200 * MS) begin
      @(posedge clk);
      hi += int'(ind);
    end
    `CHK(hi >= 96 * MS && hi <= 104 * MS, 1'b1)
    sleep_n <= 1'b0;
    repeat (8) @(posedge clk);
    `CHK({txa, rxa, ind, loe}, 11'h000)
    bus(1'b0, A_PINS, 0);
    `CHK(r[18], 1'b1)
    sleep_n <= 1'b1;
    repeat (8) @(posedge clk);
    `CHK({txa, rxa, loe}, 10'h30F)
    bus(1'b1, A_CTRL, 0);
    bus(1'b1, A_ACK, 32'h1);
    repeat (2) @(posedge clk);
    `CHK(rseen, 1'b1)
    repeat (18 * MS) @(posedge clk);
    `CHK(rseen, 1'b1)
    repeat (3 * MS) @(posedge clk);
    `CHK(rseen, 1'b0)
    b = 8'($urandom);
    bus(1'b1, A_UART_TX, {24'h0, b});
    n = 0;
    do begin
      bus(1'b0, A_IRQ_STAT, 0);
      n++;
    end while (r[4] !== 1'b1 && n < 100);
    bus(1'b0, A_UART_RX, 0);
    `CHK(r[7:0], b)
    press();
    bus(1'b0, A_IRQ_STAT, 0);
    `CHK(r[3:2], 2'b01)
    repeat (4) press();
    bus(1'b0, A_IRQ_STAT, 0);
    `CHK(r[3:2], 2'b11)
    do_reset(1'b0);
    pkt(8'($urandom));
    repeat (700 * MS) @(posedge clk);
    b = 8'($urandom) | 8'h01;
    pkt(b);
    repeat (700 * MS) @(posedge clk);
    `CHK(lout, b)
    repeat (100 * MS) @(posedge clk);
    `CHK(lout, 8'h00)
    wrap_up();
  end
endmodule
`default_nettype wire
